// *** hw/sarx_map.svh ***
// Constants of the serial audio receiver: register indices, fields, resets.
// Assumes inclusion by the receiver and its package only.
`ifndef SARX_MAP_SVH
`define SARX_MAP_SVH

// Register indices; the byte address is four times the index
`define SARX_IDX_FMT 8'h02
`define SARX_IDX_SLOT 8'h03
`define SARX_IDX_CTL3 8'h13
`define SARX_IDX_STAT 8'h20
`define SARX_IDX_SAMP 8'h21

// Format register fields
`define SARX_FMT_CODE_LO 0
`define SARX_FMT_SRC_BIT 6
`define SARX_FMT_BYP_BIT 7
// Control 3 register fields
`define SARX_CTL3_MCLK_BIT 1
`define SARX_CTL3_NARROW_BIT 2
`define SARX_CTL3_CORNER_LO 5

// Framing codes
`define SARX_FR_RJ24 3'h0
`define SARX_FR_RJ20 3'h1
`define SARX_FR_RJ18 3'h2
`define SARX_FR_RJ16 3'h3
`define SARX_FR_I2S 3'h4
`define SARX_FR_LJ 3'h5

// Reset values
`define SARX_RST_FMT 3'h4
`define SARX_RST_SLOT 4'h0
`define SARX_RST_CORNER 3'h0

// Filter shift at corner code 0 (about fs/12000 corner)
`define SARX_HPF_BASE_SHIFT 4'hb

`endif

// *** hw/sarx_pkg.sv ***
// Types of the serial audio receiver.
// Assumes the map header is compiled alongside.
package sarx_pkg;

	// Whole state of the receiver, registered in one process
	typedef struct packed {
		logic bclk_m;
		logic bclk_s;
		logic bclk_d;
		logic lr_m;
		logic lr_s;
		logic lr_d;
		logic dat_m;
		logic dat_s;
		logic [2:0] adr_m;
		logic [2:0] adr_s;
		logic rise_d;
		logic [9:0] p;
		logic [9:0] q;
		logic [9:0] period;
		logic [23:0] sh;
		logic [23:0] raw;
		logic [23:0] samp;
		logic [35:0] dc;
		logic pend;
		logic sv;
		logic [2:0] fmt;
		logic src_sel;
		logic hpf_byp;
		logic [3:0] slot_sel;
		logic mclk_ext;
		logic narrow;
		logic [2:0] corner;
	} sarx_state_t;

endpackage

// *** hw/sarx_top.sv ***
// Serial audio receiver with selectable DC-blocking filter and APB registers.
// Assumes bit clock, frame clock and data arrive from pins, far slower than mclk_in.
// Operation
// - Frame clock and data taken on bit-clock rise
// - Stereo ratios 32, 48, 64 accepted
// - Internal master clock only at stereo ratio 64 or in 16/32-bit TDM
// - Ratio 64 may use pin with select set
// - TDM frames of four or eight slots
// - 24-bit slots need external master clock
// - Auto-detect 24 or 32 bit slots
// - Slot from address offset or programmed field
// - I2S words MSB first, one clock late
// - Code 100 selects I2S, no precision
// - Code 101 left-justified, MSB at edge
// - Right-justified LSB ends at frame edges
// - Right-justified precision codes 24/20/18/16 bits
// - TDM frame starts on frame-clock rise
// - Slot count inferred from clocks per frame
// - I2S TDM slot 0 one clock late
// - Left-justified TDM slot 0 at rise
// - Right-justified TDM words end each slot
// - High-pass filter, bypass bit available
// - Corner code doubles corner each step
// - Slot select field overrides address offset
// - Slot zero right in I2S, else left
`timescale 1ns/10ps
`include "sarx_map.svh"

module sarx_top #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Serial audio port pins
	input wire logic bclk_in,
	input wire logic lrclk_in,
	input wire logic audio_data_input_in,
	input wire logic [2:0] addr_offset_in,
	// Master clock source select and filtered samples
	output logic mclk_ext_sel_out,
	output logic [23:0] sample_out,
	output logic sample_valid_out
);

	sarx_pkg::sarx_state_t s;
	sarx_pkg::sarx_state_t next_s;

	// Frame decode results
	logic be;
	logic lr_rise;
	logic tdm;
	logic fr_ok;
	logic [5:0] w_slot;
	logic [3:0] n_slots;
	logic [3:0] k;
	logic msb_al;
	logic i2s;
	logic [4:0] nbits;
	logic [9:0] st;
	logic [9:0] pos_p;
	logic [9:0] pos_q;
	logic mclk_err;
	logic [3:0] hpf_sh;
	logic signed [36:0] diff;
	logic signed [25:0] yv;
	logic [23:0] y_sat;
	logic wr;
	logic rd_hit;
	logic [ADDR_W-1:0] a_fmt;
	logic [ADDR_W-1:0] a_slot;
	logic [ADDR_W-1:0] a_ctl3;
	logic [ADDR_W-1:0] a_stat;
	logic [ADDR_W-1:0] a_samp;

	// Sign-extend the low n bits of a word to 24 bits
	function automatic logic [23:0] sext(input logic [23:0] v, input logic [4:0] n);
		case (n)
			5'd16: sext = {{8{v[15]}}, v[15:0]};
			5'd18: sext = {{6{v[17]}}, v[17:0]};
			5'd20: sext = {{4{v[19]}}, v[19:0]};
			default: sext = v;
		endcase
	endfunction

	assign a_fmt = ADDR_W'({`SARX_IDX_FMT, 2'b00});
	assign a_slot = ADDR_W'({`SARX_IDX_SLOT, 2'b00});
	assign a_ctl3 = ADDR_W'({`SARX_IDX_CTL3, 2'b00});
	assign a_stat = ADDR_W'({`SARX_IDX_STAT, 2'b00});
	assign a_samp = ADDR_W'({`SARX_IDX_SAMP, 2'b00});

	// Bit-clock rise seen after the synchronisers
	assign be = s.bclk_s & ~s.bclk_d;
	assign lr_rise = s.lr_s & ~s.lr_d;

	// Frame shape from the previous frame's length
	always_comb begin
		tdm = 1'b0;
		fr_ok = 1'b1;
		w_slot = 6'd32;
		n_slots = 4'd2;
		case (s.period)
			10'd32: begin
				w_slot = 6'd16;
			end
			10'd48: begin
				w_slot = 6'd24;
			end
			10'd64: begin
				tdm = s.narrow;
				w_slot = s.narrow ? 6'd16 : 6'd32;
				n_slots = s.narrow ? 4'd4 : 4'd2;
			end
			10'd96: begin
				tdm = 1'b1;
				fr_ok = ~s.narrow;
				w_slot = 6'd24;
				n_slots = 4'd4;
			end
			10'd128: begin
				tdm = 1'b1;
				w_slot = s.narrow ? 6'd16 : 6'd32;
				n_slots = s.narrow ? 4'd8 : 4'd4;
			end
			10'd192: begin
				tdm = 1'b1;
				fr_ok = ~s.narrow;
				w_slot = 6'd24;
				n_slots = 4'd8;
			end
			10'd256: begin
				tdm = 1'b1;
				fr_ok = ~s.narrow;
				n_slots = 4'd8;
			end
			default: begin
				fr_ok = 1'b0;
			end
		endcase
	end

	// Slot choice and capture window
	always_comb begin
		k = s.src_sel ? s.slot_sel : {1'b0, s.adr_s};
		i2s = (s.fmt == `SARX_FR_I2S);
		msb_al = i2s | (s.fmt == `SARX_FR_LJ);
		case (s.fmt)
			`SARX_FR_RJ24: nbits = 5'd24;
			`SARX_FR_RJ20: nbits = 5'd20;
			`SARX_FR_RJ18: nbits = 5'd18;
			`SARX_FR_RJ16: nbits = 5'd16;
			default: nbits = 5'd24;
		endcase
		// A word never spills out of its slot
		if ({1'b0, nbits} > w_slot) begin
			nbits = w_slot[4:0];
		end
		// Right-justified words sit at the end of the slot
		st = 10'(k * w_slot) + (msb_al ? 10'd0 : 10'(w_slot - {1'b0, nbits}));
		// Slot 0 starts at the rise, or one clock later for I2S
		pos_p = lr_rise ? 10'd0 : ((s.p == 10'h3ff) ? s.p : s.p + 10'd1);
		pos_q = (i2s ? s.rise_d : lr_rise) ? 10'd0 : s.q + 10'd1;
		// Internal master clock is only legal at 64 stereo or 16/32-bit TDM slots
		mclk_err = ~s.mclk_ext & fr_ok & (tdm ? (w_slot == 6'd24) : (s.period != 10'd64));
	end

	// Leaky-integrator DC estimate; shift shrinks as the corner code grows
	always_comb begin
		hpf_sh = `SARX_HPF_BASE_SHIFT - {1'b0, s.corner};
		diff = $signed({{2{s.raw[23]}}, s.raw, 11'h000}) - $signed({s.dc[35], s.dc});
		yv = diff[36:11];
		if (yv > 26'sd8388607) begin
			y_sat = 24'h7f_ffff;
		end else if (yv < -26'sd8388608) begin
			y_sat = 24'h80_0000;
		end else begin
			y_sat = yv[23:0];
		end
	end

	// APB: zero-wait slave, errors on unmapped addresses
	assign wr = psel_in & penable_in & pwrite_in;
	assign rd_hit = (paddr_in == a_fmt) | (paddr_in == a_slot) | (paddr_in == a_ctl3)
		| (paddr_in == a_stat) | (paddr_in == a_samp);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~rd_hit;

	// Read mux over registered state
	always_comb begin
		prdata_out = 32'h0000_0000;
		if (paddr_in == a_fmt) begin
			prdata_out[7:0] = {s.hpf_byp, s.src_sel, 3'b000, s.fmt};
		end else if (paddr_in == a_slot) begin
			prdata_out[3:0] = s.slot_sel;
		end else if (paddr_in == a_ctl3) begin
			prdata_out[7:0] = {s.corner, 2'b00, s.narrow, s.mclk_ext, 1'b0};
		end else if (paddr_in == a_stat) begin
			prdata_out[22:0] = {mclk_err, tdm, fr_ok, w_slot, n_slots, s.period};
		end else if (paddr_in == a_samp) begin
			prdata_out[23:0] = s.samp;
		end
	end

	// Next state
	always_comb begin
		next_s = s;
		next_s.sv = 1'b0;
		next_s.pend = 1'b0;
		// Two-stage synchronisers on every pin
		next_s.bclk_m = bclk_in;
		next_s.bclk_s = s.bclk_m;
		next_s.bclk_d = s.bclk_s;
		next_s.lr_m = lrclk_in;
		next_s.lr_s = s.lr_m;
		next_s.dat_m = audio_data_input_in;
		next_s.dat_s = s.dat_m;
		next_s.adr_m = addr_offset_in;
		next_s.adr_s = s.adr_m;
		// Bit timing on each bit-clock rise
		if (be) begin
			next_s.lr_d = s.lr_s;
			next_s.rise_d = lr_rise;
			next_s.p = pos_p;
			next_s.q = pos_q;
			next_s.sh = {s.sh[22:0], s.dat_s};
			if (lr_rise) begin
				next_s.period = s.p + 10'd1;
			end
			// Last bit of the chosen word closes the capture
			if (fr_ok && k < n_slots && s.fmt <= `SARX_FR_LJ
				&& pos_q == st + 10'({1'b0, nbits}) - 10'd1) begin
				next_s.raw = sext({s.sh[22:0], s.dat_s}, nbits);
				next_s.pend = 1'b1;
			end
		end
		// Filter stage one cycle after capture
		if (s.pend) begin
			next_s.sv = 1'b1;
			next_s.dc = s.dc + 36'(diff >>> hpf_sh);
			next_s.samp = s.hpf_byp ? s.raw : y_sat;
		end
		// Register writes take effect in the access phase
		if (wr && paddr_in == a_fmt) begin
			next_s.fmt = pwdata_in[`SARX_FMT_CODE_LO +: 3];
			next_s.src_sel = pwdata_in[`SARX_FMT_SRC_BIT];
			next_s.hpf_byp = pwdata_in[`SARX_FMT_BYP_BIT];
		end
		if (wr && paddr_in == a_slot) begin
			next_s.slot_sel = pwdata_in[3:0];
		end
		if (wr && paddr_in == a_ctl3) begin
			next_s.mclk_ext = pwdata_in[`SARX_CTL3_MCLK_BIT];
			next_s.narrow = pwdata_in[`SARX_CTL3_NARROW_BIT];
			next_s.corner = pwdata_in[`SARX_CTL3_CORNER_LO +: 3];
		end
	end

	// State register
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
			s.fmt <= `SARX_RST_FMT;
			s.slot_sel <= `SARX_RST_SLOT;
			s.corner <= `SARX_RST_CORNER;
		end else begin
			s <= next_s;
		end
	end

	assign mclk_ext_sel_out = s.mclk_ext;
	assign sample_out = s.samp;
	assign sample_valid_out = s.sv;

	// Checks
	sequence bit_edge;
		be;
	endsequence

	sequence frame_rise;
		be && lr_rise;
	endsequence

	a_bit_count: assert property (@(posedge mclk_in) disable iff (rst_in)
		bit_edge and !lr_rise and s.p < 10'd500 |=> s.p == $past(s.p) + 10'd1)
		else $error("bit counter did not advance on bit clock rise");

	a_frame_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
		frame_rise |=> s.p == 10'd0 && s.period == $past(s.p) + 10'd1)
		else $error("frame did not restart on frame clock rise");

	a_i2s_delay: assert property (@(posedge mclk_in) disable iff (rst_in)
		be && i2s && s.rise_d |=> s.q == 10'd0)
		else $error("I2S slot zero not one clock after rise");

	a_lj_start: assert property (@(posedge mclk_in) disable iff (rst_in)
		frame_rise and !i2s |=> s.q == 10'd0)
		else $error("left-justified slot zero not at rise");

	a_stereo_ok: assert property (@(posedge mclk_in) disable iff (rst_in)
		(s.period == 10'd48 || s.period == 10'd32) |-> fr_ok && !tdm && n_slots == 4'd2)
		else $error("stereo ratio not accepted");

	a_tdm_slots: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.period == 10'd256 && !s.narrow |-> tdm && n_slots == 4'd8 && w_slot == 6'd32)
		else $error("eight-slot frame misread");

	a_width_auto: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.period == 10'd96 && !s.narrow |-> w_slot == 6'd24 && n_slots == 4'd4)
		else $error("24-bit slots not detected");

	a_mclk_check: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s.mclk_ext && s.period == 10'd48 |-> mclk_err)
		else $error("internal master clock allowed at ratio 48");

	a_slot_pick: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s.src_sel |-> k == {1'b0, s.adr_s})
		else $error("slot not taken from address offset");

	a_sample_out: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.pend |=> sample_valid_out ##1 !sample_valid_out)
		else $error("sample not delivered as one pulse");

	a_bypass_path: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.pend && s.hpf_byp |=> sample_out == $past(s.raw))
		else $error("bypass did not pass raw sample");

	// Last bit of a right-justified word sits at the very end of its slot
	sequence rj_slot_end;
		be && fr_ok && k < n_slots && s.fmt < `SARX_FR_I2S
			&& pos_q == 10'(k * w_slot) + 10'(w_slot) - 10'd1;
	endsequence

	// MSB-aligned words stop after 16 or 24 bits of their slot
	sequence msb_word_end;
		be && fr_ok && k < n_slots && msb_al
			&& pos_q == 10'(k * w_slot) + ((w_slot == 6'd16) ? 10'd15 : 10'd23);
	endsequence

	a_rj_align: assert property (@(posedge mclk_in) disable iff (rst_in)
		rj_slot_end |=> s.pend)
		else $error("right-justified word not closed at slot end");

	a_msb_align: assert property (@(posedge mclk_in) disable iff (rst_in)
		msb_word_end |=> s.pend ##1 sample_valid_out)
		else $error("MSB-aligned word not delivered");

	a_refuse_code: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.fmt > `SARX_FR_LJ |=> !s.pend)
		else $error("reserved framing code produced a word");

	a_slot_range: assert property (@(posedge mclk_in) disable iff (rst_in)
		k >= n_slots |=> !s.pend)
		else $error("slot beyond frame produced a word");

	a_narrow_slots: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.period == 10'd128 && s.narrow |-> tdm && n_slots == 4'd8 && w_slot == 6'd16)
		else $error("eight narrow slots misread");

	a_tdm24_mclk: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s.mclk_ext && fr_ok && tdm && w_slot == 6'd24 |-> mclk_err)
		else $error("internal master clock allowed for 24-bit slots");

	a_filter_path: assert property (@(posedge mclk_in) disable iff (rst_in)
		s.pend && !s.hpf_byp |=> sample_out == $past(y_sat))
		else $error("filtered sample not delivered");

	a_sample_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		!s.pend |=> $stable(sample_out))
		else $error("sample changed without a capture");

endmodule // sarx_top

// *** tb/sarx_host_model.sv ***
// Model of the host audio source: bit clock, frame clock and serial data.
// Assumes the bench fills words and calls send_frame; bit clock idles low between calls.
`timescale 1ns/10ps
module sarx_host_model;
	logic bclk = 1'b0;
	logic lrclk = 1'b0;
	logic sdata = 1'b0;
	logic [23:0] words [8];

	// One frame at 200 ns per bit; lines move only while the bit clock is low
	task automatic send_frame(input logic [2:0] fmt, input int ratio, input int w);
		int j;
		int pos;
		int prec;
		prec = (fmt == 3'h1) ? 20 : (fmt == 3'h2) ? 18 : (fmt == 3'h3) ? 16 : 24;
		for (int i = 0; i < ratio; i++) begin
			j = (fmt == 3'h4) ? (i + ratio - 1) % ratio : i;
			pos = j % w;
			lrclk <= (i < ratio / 2);
			if (fmt[2]) begin
				sdata <= (pos < 24) ? words[j / w][23 - pos] : 1'b0;
			end else begin
				sdata <= (pos >= w - prec) ? words[j / w][w - 1 - pos] : 1'b0;
			end
			#100 bclk <= 1'b1;
			#100 bclk <= 1'b0;
		end
	endtask
endmodule // sarx_host_model

// *** tb/tb.sv ***
// Self-checking bench for the serial audio receiver, APB master tasks.
// Assumes the host model drives the audio pins; filter bypassed where values must be exact.
`timescale 1ns/10ps
module tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] addr_off = 3'h0;
	logic mclk_sel;
	logic [23:0] sample;
	logic sample_valid;
	logic [31:0] st;
	logic err;
	logic signed [23:0] e;
	int p;
	int mismatches = 0;
	int tests_run = 0;
	int valid_cnt = 0;

	sarx_host_model host();
	sarx_top sarx_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .bclk_in(host.bclk),
		.lrclk_in(host.lrclk), .audio_data_input_in(host.sdata), .addr_offset_in(addr_off),
		.mclk_ext_sel_out(mclk_sel), .sample_out(sample), .sample_valid_out(sample_valid));

	// 40 MHz system clock
	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end

	// Valid pulses seen so far; each frame may deliver one
	always @(posedge mclk_in) begin
		if (sample_valid === 1'b1) begin
			valid_cnt <= valid_cnt + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Setup then access; answer taken at the rising edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do begin
			@(posedge mclk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, st);
	endtask

	// Three frames, then room for the last word to land
	task automatic play(input logic [2:0] fmt, input int ratio, input int w, input logic [23:0] x);
		int v0;
		v0 = valid_cnt;
		repeat (3) host.send_frame(fmt, ratio, w);
		repeat (12) @(posedge mclk_in);
		chk({8'h00, sample}, {8'h00, x}, "sample");
		chk({31'b0, valid_cnt - v0 >= 2 && valid_cnt - v0 <= 3}, 32'h1, "valid pulses");
		apb(1'b0, 8'h84, 0, st);
		chk(st, {8'h00, x}, "sample reg");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the roughly 0.53 ms of traffic, still under 100k cycles
	initial begin
		#1500000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		host.words = '{24'h12_3456, 24'hA5_C3E1, 24'h7E_0102, 24'h9C_4F21, 0, 0, 0, 0};
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		// Reset values and an unmapped place
		apb(1'b0, 8'h08, 0, st);
		chk(st, 32'h0000_0004, "fmt reset");
		apb(1'b0, 8'h4C, 0, st);
		chk(st, 32'h0000_0000, "ctl3 reset");
		chk({31'b0, mclk_sel}, 32'h0, "mclk sel reset");
		apb(1'b0, 8'h10, 0, st);
		chk({st[30:0], err}, 32'h1, "unmapped");
		$display("test reset done");
		// Slot from the address offset: I2S slot 1 is left
		addr_off <= 3'h1;
		wr(8'h08, 32'h0000_0084);
		play(3'h4, 64, 32, 24'hA5_C3E1);
		apb(1'b0, 8'h80, 0, st);
		chk(st & 32'h0010_03FF, 32'h0010_0040, "status 64");
		// Programmed slot overrides the offset
		wr(8'h08, 32'h0000_00C4);
		play(3'h4, 64, 32, 24'h12_3456);
		wr(8'h08, 32'h0000_00C5);
		play(3'h5, 64, 32, 24'h12_3456);
		$display("test stereo done");
		// Right-justified precisions, sign-extended
		for (int c = 0; c < 4; c++) begin
			p = (c == 0) ? 24 : (c == 1) ? 20 : (c == 2) ? 18 : 16;
			e = $signed(host.words[0] << (24 - p)) >>> (24 - p);
			wr(8'h08, 32'h0000_00C0 | c);
			play(c[2:0], 64, 32, e);
		end
		$display("test right justified done");
		// TDM: four 32-bit slots, then four 16-bit slots
		wr(8'h0C, 32'h0000_0002);
		wr(8'h08, 32'h0000_00C5);
		play(3'h5, 128, 32, 24'h7E_0102);
		apb(1'b0, 8'h80, 0, st);
		chk(st & 32'h0030_3C00, 32'h0030_1000, "status tdm");
		wr(8'h0C, 32'h0000_0003);
		wr(8'h4C, 32'h0000_0004);
		wr(8'h08, 32'h0000_00C4);
		play(3'h4, 64, 16, 24'hFF_9C4F);
		wr(8'h4C, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0002);
		wr(8'h08, 32'h0000_00C0);
		play(3'h0, 128, 32, 24'h7E_0102);
		$display("test tdm done");
		// Pin master clock, then filter active on a large constant
		wr(8'h4C, 32'h0000_0002);
		chk({31'b0, mclk_sel}, 32'h1, "mclk sel");
		wr(8'h0C, 32'h0000_0000);
		wr(8'h08, 32'h0000_0044);
		host.words[0] = 24'h40_0000;
		repeat (3) host.send_frame(3'h4, 64, 32);
		repeat (12) @(posedge mclk_in);
		chk({31'b0, $signed(sample) > 0 && sample < 24'h40_0000}, 32'h1, "filter");
		$display("test filter done");
		// Ratio 48 with the pin master clock, then flagged with the internal one
		wr(8'h08, 32'h0000_00C4);
		play(3'h4, 48, 24, 24'h40_0000);
		apb(1'b0, 8'h80, 0, st);
		chk(st & 32'h0070_03FF, 32'h0010_0030, "status 48 pin");
		wr(8'h4C, 32'h0000_0000);
		apb(1'b0, 8'h80, 0, st);
		chk(st & 32'h0070_03FF, 32'h0050_0030, "status 48 internal");
		$display("test ratio 48 done");
		tally_and_finish();
	end
endmodule // tb
